// ---- port_service_pkg.sv ----
// shared constants and types for the interconnect port service controller
package port_service_pkg;
  localparam logic [2:0] RSP_GOOD = 3'h0;
  localparam logic [2:0] RSP_INV_REMOTE = 3'h1;
  localparam logic [2:0] RSP_REFUSED = 3'h2;
  localparam logic [2:0] RSP_NO_PHYS = 3'h3;
  localparam logic [2:0] RSP_NO_RES = 3'h4;
  localparam logic [2:0] RSP_INV_CONN = 3'h5;
  localparam logic [2:0] RSP_RCV_PEND = 3'h6;

  localparam logic [1:0] REASON_REQUESTED = 2'h0;
  localparam logic [1:0] REASON_CLOSED = 2'h1;
  localparam logic [1:0] REASON_SENSE = 2'h2;

  localparam int CLIENTS = 4;
  localparam int BUF_CHARS = 4;
  localparam int TXQ_DEPTH = 16;
  localparam logic [4:0] TXQ_DEPTH_W = 5'h10;
  localparam logic [7:0] SERIAL_REMOTE = 8'h00;
  localparam logic [7:0] INVALID_REMOTE = 8'h00;

  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_PULSE_LEN = 8'(RESET_PULSE_CYC);

  typedef enum logic [2:0] {
    OP_CONNECT = 3'b000,
    OP_LISTEN = 3'b001,
    OP_SEND = 3'b010,
    OP_RECEIVE = 3'b011,
    OP_DISCONNECT = 3'b100,
    OP_RESET = 3'b101
  } req_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_OPEN = 1'b1
  } conn_state_t;
endpackage

// ---- line_sync.sv ----
// two-flop synchroniser with edge detection on a registered sample
`timescale 1ns/10ps
module line_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic last;

  // meta feeds only sync; edges compare two settled samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= d;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign rise = sync & ~last;
  assign fall = ~sync & last;
endmodule

// ---- port_service_ctrl.sv ----
// connection service controller for one interconnect port
`timescale 1ns/10ps
module port_service_ctrl (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SIDE_AUTOMATION,
  input wire logic PORT_NETWORK,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_OP,
  input wire logic [1:0] REQ_CLIENT,
  input wire logic [1:0] REQ_CONN,
  input wire logic [7:0] REQ_REMOTE,
  input wire logic [2:0] REQ_SIZE,
  input wire logic [31:0] REQ_DATA,
  output logic RSP_VALID,
  output logic [2:0] RSP_CODE,
  output logic IND_CONNECTED,
  output logic IND_RECEIVED,
  output logic IND_DISCONNECTED,
  output logic IND_RESET_RCVD,
  output logic [1:0] IND_CLIENT,
  output logic [1:0] IND_CONN,
  output logic [7:0] IND_REMOTE,
  output logic [2:0] IND_COUNT,
  output logic [31:0] IND_DATA,
  output logic [1:0] IND_REASON,
  input wire logic SENSE_IN,
  input wire logic RESET_LINE_IN,
  output logic RESET_LINE_OUT,
  input wire logic PEER_LISTENING,
  input wire logic PEER_CONNECT,
  input wire logic [7:0] PEER_PORT,
  input wire logic TCP_LOST,
  output logic [7:0] TX_CHAR,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [7:0] RX_CHAR,
  input wire logic RX_VALID
);
  function automatic logic [2:0] clamp_size(input logic [2:0] s);
    clamp_size = (s > 3'(port_service_pkg::BUF_CHARS)) ?
      3'(port_service_pkg::BUF_CHARS) : s;
  endfunction

  function automatic logic [1:0] first_waiting(input logic [3:0] m);
    first_waiting = 2'h0;
    for (int i = port_service_pkg::CLIENTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_waiting = 2'(i);
      end
    end
  endfunction

  port_service_pkg::conn_state_t st;
  logic [3:0] listen_mask;
  logic sense_lvl;
  logic sense_fall;
  logic rst_line_rise;
  logic [7:0] txq [port_service_pkg::TXQ_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] used;
  logic [4:0] free;
  logic rcv_pend;
  logic [2:0] rcv_max;
  logic [2:0] rcv_cnt;
  logic [31:0] rcv_buf;
  logic [31:0] next_buf;
  logic [7:0] pulse_cnt;

  logic is_req;
  logic conn_valid;
  logic [2:0] send_n;
  logic send_ok;
  logic rcv_start;
  logic port_reset;
  logic close_evt;
  logic closing;
  logic pop;

  line_sync sense_sync (
    .clk(REF_CLK), .rst(RST), .d(SENSE_IN),
    .level(sense_lvl), .rise(), .fall(sense_fall)
  );
  line_sync reset_sync (
    .clk(REF_CLK), .rst(RST), .d(RESET_LINE_IN),
    .level(), .rise(rst_line_rise), .fall()
  );

  always_comb begin
    is_req = REQ_VALID;
    conn_valid = (st == port_service_pkg::ST_OPEN) && (REQ_CONN == IND_CONN);
    send_n = clamp_size(REQ_SIZE);
    free = port_service_pkg::TXQ_DEPTH_W - used;
    send_ok = is_req && (REQ_OP == port_service_pkg::OP_SEND) &&
      conn_valid && ({2'h0, send_n} <= free);
    rcv_start = is_req && (REQ_OP == port_service_pkg::OP_RECEIVE) &&
      conn_valid && !rcv_pend && (REQ_SIZE != 3'h0);
    port_reset = (is_req && (REQ_OP == port_service_pkg::OP_RESET) &&
      SIDE_AUTOMATION) || (!SIDE_AUTOMATION && rst_line_rise);
    close_evt = (st == port_service_pkg::ST_OPEN) &&
      (sense_fall || (PORT_NETWORK && TCP_LOST));
    closing = port_reset || close_evt ||
      (is_req && (REQ_OP == port_service_pkg::OP_DISCONNECT) && conn_valid);
    pop = (used != 5'h0) && (!TX_VALID || TX_READY);
  end

  // connection state, responses and connection indications
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st <= port_service_pkg::ST_IDLE;
      listen_mask <= 4'h0;
      RSP_VALID <= 1'b0;
      RSP_CODE <= port_service_pkg::RSP_GOOD;
      IND_CONNECTED <= 1'b0;
      IND_DISCONNECTED <= 1'b0;
      IND_RESET_RCVD <= 1'b0;
      IND_CLIENT <= 2'h0;
      IND_CONN <= 2'h0;
      IND_REMOTE <= 8'h00;
      IND_REASON <= port_service_pkg::REASON_REQUESTED;
    end else begin
      RSP_VALID <= is_req;
      IND_CONNECTED <= 1'b0;
      IND_DISCONNECTED <= 1'b0;
      IND_RESET_RCVD <= 1'b0;
      if (is_req) begin
        unique case (REQ_OP)
          port_service_pkg::OP_CONNECT: begin
            if (st == port_service_pkg::ST_OPEN || listen_mask != 4'h0) begin
              RSP_CODE <= port_service_pkg::RSP_REFUSED;
            end else if (!sense_lvl) begin
              RSP_CODE <= port_service_pkg::RSP_NO_PHYS;
            end else if (PORT_NETWORK &&
                         REQ_REMOTE == port_service_pkg::INVALID_REMOTE) begin
              RSP_CODE <= port_service_pkg::RSP_INV_REMOTE;
            end else if (PORT_NETWORK && !PEER_LISTENING) begin
              RSP_CODE <= port_service_pkg::RSP_REFUSED;
            end else begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
              st <= port_service_pkg::ST_OPEN;
              IND_CONNECTED <= 1'b1;
              IND_CLIENT <= REQ_CLIENT;
              IND_CONN <= IND_CONN + 2'h1;
              // serial port has no remote addressing
              IND_REMOTE <= PORT_NETWORK ? REQ_REMOTE :
                port_service_pkg::SERIAL_REMOTE;
            end
          end
          port_service_pkg::OP_LISTEN: begin
            if (st == port_service_pkg::ST_OPEN ||
                listen_mask[REQ_CLIENT]) begin
              RSP_CODE <= port_service_pkg::RSP_REFUSED;
            end else if (!sense_lvl) begin
              RSP_CODE <= port_service_pkg::RSP_NO_PHYS;
            end else if (PORT_NETWORK) begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
              listen_mask[REQ_CLIENT] <= 1'b1;
            end else begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
              st <= port_service_pkg::ST_OPEN;
              IND_CONNECTED <= 1'b1;
              IND_CLIENT <= REQ_CLIENT;
              IND_CONN <= IND_CONN + 2'h1;
              IND_REMOTE <= port_service_pkg::SERIAL_REMOTE;
            end
          end
          port_service_pkg::OP_SEND: begin
            if (!conn_valid) begin
              RSP_CODE <= port_service_pkg::RSP_INV_CONN;
            end else if (!send_ok) begin
              RSP_CODE <= port_service_pkg::RSP_NO_RES;
            end else begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
            end
          end
          port_service_pkg::OP_RECEIVE: begin
            if (!conn_valid) begin
              RSP_CODE <= port_service_pkg::RSP_INV_CONN;
            end else if (rcv_pend) begin
              RSP_CODE <= port_service_pkg::RSP_RCV_PEND;
            end else begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
            end
          end
          port_service_pkg::OP_DISCONNECT: begin
            if (!conn_valid) begin
              RSP_CODE <= port_service_pkg::RSP_INV_CONN;
            end else begin
              RSP_CODE <= port_service_pkg::RSP_GOOD;
              st <= port_service_pkg::ST_IDLE;
              IND_DISCONNECTED <= 1'b1;
              IND_REASON <= port_service_pkg::REASON_REQUESTED;
            end
          end
          port_service_pkg::OP_RESET: begin
            RSP_CODE <= SIDE_AUTOMATION ? port_service_pkg::RSP_GOOD :
              port_service_pkg::RSP_INV_CONN;
          end
          default: begin
            RSP_CODE <= port_service_pkg::RSP_INV_CONN;
          end
        endcase
      end else if (PORT_NETWORK && PEER_CONNECT && sense_lvl &&
                   st == port_service_pkg::ST_IDLE && listen_mask != 4'h0) begin
        // incoming network connection served to the lowest waiting client
        st <= port_service_pkg::ST_OPEN;
        listen_mask[first_waiting(listen_mask)] <= 1'b0;
        IND_CONNECTED <= 1'b1;
        IND_CLIENT <= first_waiting(listen_mask);
        IND_CONN <= IND_CONN + 2'h1;
        IND_REMOTE <= PEER_PORT;
      end
      // line events override a request in the same cycle
      if (close_evt && !port_reset) begin
        st <= port_service_pkg::ST_IDLE;
        IND_CONNECTED <= 1'b0;
        IND_DISCONNECTED <= 1'b1;
        IND_REASON <= sense_fall ? port_service_pkg::REASON_SENSE :
          port_service_pkg::REASON_CLOSED;
      end
      if (port_reset) begin
        st <= port_service_pkg::ST_IDLE;
        listen_mask <= 4'h0;
        IND_CONNECTED <= 1'b0;
        IND_DISCONNECTED <= 1'b0;
        IND_RESET_RCVD <= !SIDE_AUTOMATION;
      end
    end
  end

  // transmit queue: whole send captured at once, drained in order
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      used <= 5'h00;
      TX_VALID <= 1'b0;
      TX_CHAR <= 8'h00;
    end else if (port_reset || (close_evt && sense_fall)) begin
      // a dead link cannot carry queued characters, so they are dropped
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      used <= 5'h00;
      TX_VALID <= 1'b0;
    end else begin
      if (send_ok) begin
        for (int i = 0; i < port_service_pkg::BUF_CHARS; i++) begin
          if (3'(i) < send_n) begin
            txq[wr_ptr + 4'(i)] <= REQ_DATA[8*i +: 8];
          end
        end
        wr_ptr <= wr_ptr + {1'b0, send_n};
      end
      if (pop) begin
        TX_CHAR <= txq[rd_ptr];
        TX_VALID <= 1'b1;
        rd_ptr <= rd_ptr + 4'h1;
      end else if (TX_READY) begin
        TX_VALID <= 1'b0;
      end
      used <= used + (send_ok ? {2'h0, send_n} : 5'h00) -
        (pop ? 5'h01 : 5'h00);
    end
  end

  always_comb begin
    next_buf = rcv_buf;
    next_buf[8*rcv_cnt[1:0] +: 8] = RX_CHAR;
  end

  // receive assembly; delivery may split or merge sends
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rcv_pend <= 1'b0;
      rcv_max <= 3'h0;
      rcv_cnt <= 3'h0;
      rcv_buf <= 32'h0;
      IND_RECEIVED <= 1'b0;
      IND_COUNT <= 3'h0;
      IND_DATA <= 32'h0;
    end else begin
      IND_RECEIVED <= 1'b0;
      if (closing) begin
        rcv_pend <= 1'b0;
        rcv_cnt <= 3'h0;
      end else if (rcv_start) begin
        rcv_pend <= 1'b1;
        rcv_max <= clamp_size(REQ_SIZE);
        rcv_cnt <= 3'h0;
        rcv_buf <= 32'h0;
      end else if (rcv_pend && RX_VALID) begin
        rcv_buf <= next_buf;
        if (rcv_cnt + 3'h1 == rcv_max) begin
          rcv_pend <= 1'b0;
          IND_RECEIVED <= 1'b1;
          IND_COUNT <= rcv_max;
          IND_DATA <= next_buf;
          rcv_cnt <= 3'h0;
        end else begin
          rcv_cnt <= rcv_cnt + 3'h1;
        end
      end else if (rcv_pend && rcv_cnt != 3'h0) begin
        // a gap on the line ends a partial delivery early
        rcv_pend <= 1'b0;
        IND_RECEIVED <= 1'b1;
        IND_COUNT <= rcv_cnt;
        IND_DATA <= rcv_buf;
        rcv_cnt <= 3'h0;
      end
    end
  end

  // reset line toward the drive held for a fixed pulse
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pulse_cnt <= 8'h00;
      RESET_LINE_OUT <= 1'b0;
    end else begin
      if (port_reset && SIDE_AUTOMATION) begin
        pulse_cnt <= port_service_pkg::RESET_PULSE_LEN;
        RESET_LINE_OUT <= 1'b1;
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
        RESET_LINE_OUT <= (pulse_cnt != 8'h01);
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_reset_req;
    is_req && REQ_OP == port_service_pkg::OP_RESET && SIDE_AUTOMATION;
  endsequence
  sequence s_line_held;
    RESET_LINE_OUT [*8];
  endsequence

  a_rsp_strobe: assert property (is_req |=> RSP_VALID)
    else $error("request not answered next cycle");
  a_second_open: assert property (is_req && REQ_OP ==
    port_service_pkg::OP_CONNECT && st == port_service_pkg::ST_OPEN
    |=> RSP_CODE == port_service_pkg::RSP_REFUSED)
    else $error("second connection not refused");
  a_connect_nophys: assert property (is_req && REQ_OP ==
    port_service_pkg::OP_CONNECT && st == port_service_pkg::ST_IDLE &&
    listen_mask == 4'h0 && !sense_lvl && !port_reset
    |=> RSP_CODE == port_service_pkg::RSP_NO_PHYS && !IND_CONNECTED)
    else $error("connect without sense not failed");
  a_serial_connected: assert property (!PORT_NETWORK && is_req &&
    REQ_OP == port_service_pkg::OP_LISTEN && st == port_service_pkg::ST_IDLE
    && sense_lvl && !close_evt && !port_reset
    |=> IND_CONNECTED && IND_REMOTE == port_service_pkg::SERIAL_REMOTE)
    else $error("serial listen did not connect at once");
  a_connected_cause: assert property (IND_CONNECTED |->
    $past(is_req) || $past(PEER_CONNECT))
    else $error("connected without a request");
  a_send_full: assert property (is_req &&
    REQ_OP == port_service_pkg::OP_SEND && conn_valid &&
    {2'h0, send_n} > free
    |=> RSP_CODE == port_service_pkg::RSP_NO_RES)
    else $error("overfull send not refused");
  a_rcv_pending: assert property (is_req && REQ_OP ==
    port_service_pkg::OP_RECEIVE && conn_valid && rcv_pend
    |=> RSP_CODE == port_service_pkg::RSP_RCV_PEND)
    else $error("second receive not rejected");
  a_rcv_limit: assert property (IND_RECEIVED |->
    IND_COUNT != 3'h0 && IND_COUNT <= $past(rcv_max))
    else $error("received count beyond limit");
  a_rcv_closed: assert property (IND_RECEIVED |->
    $past(st) == port_service_pkg::ST_OPEN && !$past(closing))
    else $error("received after disconnect");
  a_send_closed: assert property (is_req && REQ_OP ==
    port_service_pkg::OP_SEND && st == port_service_pkg::ST_IDLE
    |=> RSP_CODE == port_service_pkg::RSP_INV_CONN)
    else $error("send after close not rejected");
  a_reset_line: assert property (s_reset_req |=> s_line_held)
    else $error("reset line not held");
  a_reset_rcvd: assert property (!SIDE_AUTOMATION && rst_line_rise
    |=> IND_RESET_RCVD && st == port_service_pkg::ST_IDLE)
    else $error("reset received not signalled");
endmodule

// ---- peer_port.sv ----
// peer side model: character sink with stalls, character source on demand
`timescale 1ns/10ps
module peer_port (
  input wire logic clk,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_char,
  output logic rx_valid
);
  logic [7:0] got[$];
  logic stall;
  logic [31:0] lfsr;
  initial begin
    stall = 1'b0;
    lfsr = 32'h1;
    tx_ready = 1'b0;
    rx_char = 8'h00;
    rx_valid = 1'b0;
  end
  // ready comes and goes, so the queue sees prompt and slow draining
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_char);
    end
    lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    tx_ready <= !stall && lfsr[0];
  end
  task automatic put(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
  endtask
  // a released data line shows the inverse of its last value
  task automatic idle;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~rx_char;
  endtask
endmodule

// ---- interconnect_port_service_ctrl_test.sv ----
// self-checking bench for the port service controller with a peer model
`timescale 1ns/10ps
module interconnect_port_service_ctrl_test;
  logic ref_clk, rst, side_auto, port_net, req_valid, rsp_valid, open_seen;
  logic [2:0] req_op, req_size, rsp_code, ind_count, got_count, code;
  logic [1:0] req_client, req_conn, ind_client, ind_conn, ind_reason;
  logic [1:0] got_reason, conn_id;
  logic [7:0] req_remote, ind_remote, peer_port_id, tx_char, rx_char;
  logic [31:0] req_data, ind_data, got_data, seed;
  logic ind_c, ind_r, ind_d, ind_rr, sense, reset_in, reset_out;
  logic peer_listen, peer_conn, tcp_lost, tx_valid, tx_ready, rx_valid;
  logic [7:0] exp_q[$];
  int err_total, compares;
  int ind_n[4], mark[4];

  port_service_ctrl u_dut (
    .REF_CLK(ref_clk), .RST(rst), .SIDE_AUTOMATION(side_auto),
    .PORT_NETWORK(port_net), .REQ_VALID(req_valid), .REQ_OP(req_op),
    .REQ_CLIENT(req_client), .REQ_CONN(req_conn), .REQ_REMOTE(req_remote),
    .REQ_SIZE(req_size), .REQ_DATA(req_data), .RSP_VALID(rsp_valid),
    .RSP_CODE(rsp_code), .IND_CONNECTED(ind_c), .IND_RECEIVED(ind_r),
    .IND_DISCONNECTED(ind_d), .IND_RESET_RCVD(ind_rr),
    .IND_CLIENT(ind_client), .IND_CONN(ind_conn), .IND_REMOTE(ind_remote),
    .IND_COUNT(ind_count), .IND_DATA(ind_data), .IND_REASON(ind_reason),
    .SENSE_IN(sense), .RESET_LINE_IN(reset_in), .RESET_LINE_OUT(reset_out),
    .PEER_LISTENING(peer_listen), .PEER_CONNECT(peer_conn),
    .PEER_PORT(peer_port_id), .TCP_LOST(tcp_lost), .TX_CHAR(tx_char),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_CHAR(rx_char),
    .RX_VALID(rx_valid)
  );
  peer_port u_peer (
    .clk(ref_clk), .tx_char(tx_char), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #(port_service_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // a burst of a characters against a receive of size n
  function automatic logic [2:0] deliver(input logic [2:0] n, input int a);
    return (int'(n) < a) ? n : 3'(a);
  endfunction
  function automatic logic [31:0] keep(input logic [2:0] n);
    return (n >= 3'h4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // code 7 is never answered, so it stands for either outcome
  task automatic req(input logic [2:0] op, input logic [1:0] cl,
                     input logic [7:0] rm, input logic [2:0] sz,
                     input logic [31:0] d, input logic [2:0] exp);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_client <= cl;
    req_conn <= conn_id;
    req_remote <= rm;
    req_size <= sz;
    req_data <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_data <= ~d;
    #1;
    chk(32'(rsp_valid), 32'h1, "response strobe");
    code = rsp_code;
    if (exp !== 3'h7) chk(32'(code), 32'(exp), "response code");
  endtask
  task automatic wait_ind(input int k, input int lim);
    for (int i = 0; i < lim && ind_n[k] == mark[k]; i++) @(posedge ref_clk);
    #1;
    chk(32'(ind_n[k] - mark[k]), 32'h1, "indication count");
  endtask
  task automatic set_sense(input logic v);
    @(posedge ref_clk);
    sense <= v;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset(input logic a, input logic n);
    @(posedge ref_clk);
    rst <= 1'b1;
    side_auto <= a;
    port_net <= n;
    sense <= 1'b0;
    peer_listen <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    conn_id = 2'h0;
    open_seen = 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (ind_c === 1'b1) begin
      ind_n[0]++;
      open_seen = 1'b1;
    end
    if (ind_r === 1'b1) begin
      ind_n[1]++;
      got_count = ind_count;
      got_data = ind_data;
      if (!open_seen) chk(32'h1, 32'h0, "received while closed");
    end
    if (ind_d === 1'b1) begin
      ind_n[2]++;
      open_seen = 1'b0;
      got_reason = ind_reason;
    end
    if (ind_rr === 1'b1) ind_n[3]++;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end

  initial begin
    int n, a;
    logic [31:0] d;
    logic [2:0] s;
    logic [7:0] r;
    {rst, side_auto, port_net, req_valid, sense, reset_in} = 6'h20;
    {peer_listen, peer_conn, tcp_lost, req_op, req_size} = 9'h000;
    {req_client, req_conn, req_remote, req_data, peer_port_id} = '0;
    seed = 32'ha82698a5;
    err_total = 0;
    compares = 0;
    ind_n = '{default: 0};
    do_reset(1'b1, 1'b0);
    // sense is still low, so there is no physical link yet
    req(port_service_pkg::OP_CONNECT, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_NO_PHYS);
    set_sense(1'b1);
    mark = ind_n;
    req(port_service_pkg::OP_CONNECT, 2'h2, 8'(rnd()) | 8'h01, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    conn_id++;
    wait_ind(0, 2);
    chk(32'(ind_client), 32'h2, "connected client");
    chk(32'(ind_conn), 32'(conn_id), "connection id");
    chk(32'(ind_remote), 32'(port_service_pkg::SERIAL_REMOTE), "remote");
    req(port_service_pkg::OP_CONNECT, 2'h2, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_REFUSED);
    chk(32'(u_peer.got.size()), 32'h0, "link silent on connect");
    chk(32'(ind_n[0] - mark[0]), 32'h1, "extra connected");
    // fill the transmit queue while the peer stalls
    u_peer.stall = 1'b1;
    n = 0;
    code = port_service_pkg::RSP_GOOD;
    for (int i = 0; i < 8 && code !== port_service_pkg::RSP_NO_RES; i++) begin
      d = rnd();
      req(port_service_pkg::OP_SEND, 2'h0, 8'h00, 3'h4, d, 3'h7);
      if (code === port_service_pkg::RSP_GOOD) begin
        n++;
        for (int b = 0; b < 4; b++) exp_q.push_back(d[8*b +: 8]);
      end
    end
    chk(32'(code), 32'(port_service_pkg::RSP_NO_RES), "full queue");
    chk(32'(n >= port_service_pkg::TXQ_DEPTH / 4), 32'h1, "accepted");
    u_peer.stall = 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = rnd();
      s = 3'(d[31:29] % 3'h5);
      req(port_service_pkg::OP_SEND, 2'h0, 8'h00, s, d, 3'h7);
      if (code === port_service_pkg::RSP_GOOD) begin
        for (int b = 0; b < int'(s); b++) exp_q.push_back(d[8*b +: 8]);
      end else begin
        chk(32'(code), 32'(port_service_pkg::RSP_NO_RES), "send");
      end
    end
    for (int i = 0; i < 400 && u_peer.got.size() < exp_q.size(); i++) begin
      @(posedge ref_clk);
    end
    chk(32'(u_peer.got.size()), 32'(exp_q.size()), "tx count");
    foreach (exp_q[i]) chk(32'(u_peer.got[i]), 32'(exp_q[i]), "tx");
    for (int k = 0; k < 6; k++) begin
      d = rnd();
      s = 3'(d[1:0]) + 3'h1;
      a = int'(d[4:3]) + 1;
      mark = ind_n;
      req(port_service_pkg::OP_RECEIVE, 2'h0, 8'h00, s, 32'h0,
          port_service_pkg::RSP_GOOD);
      if (k == 0) req(port_service_pkg::OP_RECEIVE, 2'h0, 8'h00, s, 32'h0,
                      port_service_pkg::RSP_RCV_PEND);
      for (int b = 0; b < a; b++) u_peer.put(d[8*b +: 8]);
      u_peer.idle();
      wait_ind(1, 8);
      chk(32'(got_count), 32'(deliver(s, a)), "received count");
      chk(got_data & keep(deliver(s, a)), d & keep(deliver(s, a)),
          "received data");
    end
    req(port_service_pkg::OP_RECEIVE, 2'h0, 8'h00, 3'h4, 32'h0,
        port_service_pkg::RSP_GOOD);
    mark = ind_n;
    req(port_service_pkg::OP_DISCONNECT, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    wait_ind(2, 3);
    chk(32'(got_reason), 32'(port_service_pkg::REASON_REQUESTED), "why");
    u_peer.put(8'h5a);
    u_peer.idle();
    repeat (4) @(posedge ref_clk);
    chk(32'(ind_n[1] - mark[1]), 32'h0, "received after close");
    req(port_service_pkg::OP_SEND, 2'h0, 8'h00, 3'h1, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    req(port_service_pkg::OP_RECEIVE, 2'h0, 8'h00, 3'h1, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    req(port_service_pkg::OP_DISCONNECT, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    req(port_service_pkg::OP_CONNECT, 2'h1, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    conn_id++;
    mark = ind_n;
    set_sense(1'b0);
    wait_ind(2, 4);
    chk(32'(got_reason), 32'(port_service_pkg::REASON_SENSE), "why");
    set_sense(1'b1);
    req(port_service_pkg::OP_LISTEN, 2'h1, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    conn_id++;
    mark = ind_n;
    req(port_service_pkg::OP_RESET, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    n = 0;
    while (reset_out === 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(n), 32'(port_service_pkg::RESET_PULSE_CYC), "line");
    chk(32'(ind_n[2] - mark[2]), 32'h0, "closed on reset");
    req(port_service_pkg::OP_SEND, 2'h0, 8'h00, 3'h1, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    do_reset(1'b0, 1'b1);
    req(port_service_pkg::OP_CONNECT, 2'h3, 8'h05, 3'h0, 32'h0,
        port_service_pkg::RSP_NO_PHYS);
    set_sense(1'b1);
    req(port_service_pkg::OP_CONNECT, 2'h3, port_service_pkg::INVALID_REMOTE,
        3'h0, 32'h0, port_service_pkg::RSP_INV_REMOTE);
    req(port_service_pkg::OP_CONNECT, 2'h3, 8'h05, 3'h0, 32'h0,
        port_service_pkg::RSP_REFUSED);
    @(posedge ref_clk);
    peer_listen <= 1'b1;
    r = 8'(rnd()) | 8'h01;
    mark = ind_n;
    req(port_service_pkg::OP_CONNECT, 2'h3, r, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    conn_id++;
    wait_ind(0, 2);
    chk(32'(ind_remote), 32'(r), "network remote");
    mark = ind_n;
    @(posedge ref_clk);
    tcp_lost <= 1'b1;
    @(posedge ref_clk);
    tcp_lost <= 1'b0;
    wait_ind(2, 4);
    chk(32'(got_reason), 32'(port_service_pkg::REASON_CLOSED), "why");
    req(port_service_pkg::OP_RESET, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    mark = ind_n;
    @(posedge ref_clk);
    reset_in <= 1'b1;
    wait_ind(3, 8);
    chk(32'(reset_out), 32'h0, "drive side line out");
    @(posedge ref_clk);
    reset_in <= 1'b0;
    req(3'h6, 2'h0, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_INV_CONN);
    do_reset(1'b0, 1'b1);
    req(port_service_pkg::OP_LISTEN, 2'h1, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_NO_PHYS);
    set_sense(1'b1);
    mark = ind_n;
    req(port_service_pkg::OP_LISTEN, 2'h2, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    req(port_service_pkg::OP_LISTEN, 2'h1, 8'h00, 3'h0, 32'h0,
        port_service_pkg::RSP_GOOD);
    req(port_service_pkg::OP_CONNECT, 2'h3, 8'h05, 3'h0, 32'h0,
        port_service_pkg::RSP_REFUSED);
    chk(32'(ind_n[0] - mark[0]), 32'h0, "early connected");
    r = 8'(rnd()) | 8'h01;
    @(posedge ref_clk);
    peer_conn <= 1'b1;
    peer_port_id <= r;
    @(posedge ref_clk);
    peer_conn <= 1'b0;
    wait_ind(0, 4);
    chk(32'(ind_client), 32'h1, "lowest waiting client");
    chk(32'(ind_remote), 32'(r), "peer remote");
    summarize();
  end
endmodule
